// >>> logic/aicr_pkg.sv
// Purpose: constants and types for the converter interface register bank
// Assumes: byte-wide registers reached over a four-wire serial port
// Notes: identity values are parameters of the top module
package aicr_pkg;

  // register offsets
  localparam logic [6:0] ADDR_SETUP_A = 7'h00;
  localparam logic [6:0] ADDR_SETUP_B = 7'h01;
  localparam logic [6:0] ADDR_STATE_POWER = 7'h02;
  localparam logic [6:0] ADDR_PART_CLASS = 7'h03;
  localparam logic [6:0] ADDR_PART_NUM_LO = 7'h04;
  localparam logic [6:0] ADDR_PART_NUM_HI = 7'h05;
  localparam logic [6:0] ADDR_GRADE_VER = 7'h06;
  localparam logic [6:0] ADDR_SILICON_REV = 7'h07;
  localparam logic [6:0] ADDR_SCRATCH = 7'h0a;
  localparam logic [6:0] ADDR_PROTO_REV = 7'h0b;
  localparam logic [6:0] ADDR_MAKER_LO = 7'h0c;
  localparam logic [6:0] ADDR_MAKER_HI = 7'h0d;
  localparam logic [6:0] ADDR_LOOP_DEPTH = 7'h0e;
  localparam logic [6:0] ADDR_XFER = 7'h0f;
  localparam logic [6:0] ADDR_OPTIONS = 7'h10;
  localparam logic [6:0] ADDR_FRAME = 7'h11;
  localparam logic [6:0] ADDR_LANES = 7'h12;
  localparam logic [6:0] ADDR_POWER_DOWN = 7'h13;

  // field positions
  localparam int A_RESET = 7;
  localparam int A_ASCEND = 5;
  localparam int A_DRIVE = 4;
  localparam int A_DRIVE_SH = 3;
  localparam int A_ASCEND_SH = 2;
  localparam int A_RESET_SH = 0;
  localparam int B_ONE_SHOT = 7;
  localparam int B_RDSEL = 5;
  localparam int B_IF_CLEAR = 1;
  localparam int S_IDLE = 5;
  localparam int S_NO_ERR = 4;
  localparam int S_POWER = 0;
  localparam logic [7:0] STATE_FIXED_ONES = 8'hc0;
  localparam logic [7:0] POWER_DOWN_MASK = 8'h7b;

  // reset values
  localparam logic [7:0] RST_SETUP_A = 8'h18;
  localparam logic [7:0] RST_SETUP_B = 8'h80;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // soft reset duration
  localparam int CLK_PERIOD_PS = 5000;
  localparam int SOFT_RESET_NS = 100;
  localparam int SOFT_RESET_CYCLES =
    (SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // frame lengths in bits
  localparam logic [5:0] FRAME_BITS_16 = 6'd16;
  localparam logic [5:0] FRAME_BITS_16C = 6'd22;
  localparam logic [5:0] FRAME_BITS_24 = 6'd24;
  localparam logic [5:0] FRAME_BITS_24C = 6'd30;

  typedef struct packed {
    logic ascend;
    logic drive_on;
    logic one_shot;
    logic rdsel;
    logic if_clear;
    logic power_high;
    logic [7:0] scratch;
    logic [7:0] loop_depth;
    logic xfer;
    logic [3:0] options;
    logic seed_policy;
    logic [1:0] frame;
    logic [3:0] divider;
    logic [7:0] lanes;
    logic [7:0] power_down;
  } aicr_regs_s;

  localparam aicr_regs_s REGS_RESET = '{
    ascend: 1'b0, drive_on: 1'b1, one_shot: 1'b1, rdsel: 1'b0,
    if_clear: 1'b0, power_high: 1'b0, scratch: 8'h00,
    loop_depth: 8'h00, xfer: 1'b0, options: 4'h0, seed_policy: 1'b0,
    frame: 2'h0, divider: 4'h0, lanes: 8'h00, power_down: 8'h00};

  typedef struct packed {
    logic power_high;
    logic antialias_select;
    logic shared_out_source;
    logic ref_gain_fix_on;
    logic crystal_clock_out_on;
    logic check_seed_policy;
    logic [1:0] frame_code;
    logic [5:0] frame_bits;
    logic [3:0] data_clock_divider;
    logic [4:0] chain_count;
    logic [1:0] mean_select;
    logic [1:0] lane_format;
    logic [3:0] lane_out_en;
    logic [3:0] lane_chain_in;
    logic readback_first_stage;
    logic transfer_pulse;
    logic interface_logic_clear;
    logic [7:0] power_down;
    logic soft_reset_active;
  } aicr_cfg_s;

endpackage : aicr_pkg

// >>> logic/aicr_regbank.sv
// Purpose: serial-port register bank for interface and output setup
// Assumes: serial clock idles low, data sampled on its rising edge;
//   header byte is read flag then 7-bit address, data bytes follow
// Notes: serial port pins pass two flip-flops before use; lane zero input passes one
`timescale 1ns/1ps

module aicr_regbank
  import aicr_pkg::*;
#(
  parameter logic [7:0] PART_CLASS = 8'h11,   // value arbitrary
  parameter logic [15:0] PART_NUMBER = 16'h1234, // value arbitrary
  parameter logic [7:0] GRADE_VERSION = 8'h00, // value arbitrary
  parameter logic [7:0] SILICON_REV = 8'h01,  // value arbitrary
  parameter logic [7:0] PROTO_REV = 8'h01,    // value arbitrary
  parameter logic [15:0] MAKER_CODE = 16'h5a5a, // value arbitrary
  parameter int ERR_WIDTH = 8
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // serial port pins
  input wire logic serial_clk_i,
  input wire logic serial_cs_n_i,
  input wire logic serial_data_i,
  output logic shared_serial_out_o,
  output logic shared_serial_out_oe_o,
  // device status
  input wire logic busy_i,
  input wire logic [ERR_WIDTH-1:0] error_flags_i,
  input wire logic [ERR_WIDTH-1:0] error_enable_i,
  input wire logic data_out_lane_zero_i,
  // configuration to the converter core
  output aicr_cfg_s cfg_o
);

  initial begin
    if (ERR_WIDTH < 1) begin
      $error("ERR_WIDTH must be at least one");
    end
  end

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [1:0] sdi_s;
    logic [2:0] bitcnt;
    logic hdr_done;
    logic rd;
    logic refused;
    logic [6:0] addr;
    logic [6:0] start;
    logic [7:0] loopcnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic sdo;
    logic lane_q;
    logic resetting;
    logic [4:0] rst_cnt;
    logic xfer_pulse;
    aicr_regs_s regs;
  } aicr_state_s;

  localparam logic [4:0] RST_LAST = 5'(SOFT_RESET_CYCLES - 1);

  aicr_state_s st;
  aicr_state_s next_st;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_on;
  logic cs_rise;
  logic byte_done;
  logic [7:0] byte_in;
  logic no_err;
  logic idle;
  logic [6:0] step_addr;
  logic [7:0] rd_hdr;
  logic [7:0] rd_step;
  logic [7:0] rd_state;

  function automatic logic [7:0] read_reg(input logic [6:0] a,
                                          input aicr_regs_s r,
                                          input logic rst_on,
                                          input logic idle_b,
                                          input logic ok_b);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      ADDR_SETUP_A: begin
        d[A_RESET] = rst_on;
        d[A_RESET_SH] = rst_on;
        d[A_ASCEND] = r.ascend;
        d[A_ASCEND_SH] = r.ascend;
        d[A_DRIVE] = r.drive_on;
        d[A_DRIVE_SH] = r.drive_on;
      end
      ADDR_SETUP_B: begin
        d[B_ONE_SHOT] = r.one_shot;
        d[B_RDSEL] = r.rdsel;
        d[B_IF_CLEAR] = r.if_clear;
      end
      ADDR_STATE_POWER: begin
        d = STATE_FIXED_ONES;
        d[S_IDLE] = idle_b;
        d[S_NO_ERR] = ok_b;
        d[S_POWER] = r.power_high;
      end
      ADDR_PART_CLASS: d = PART_CLASS;
      ADDR_PART_NUM_LO: d = PART_NUMBER[7:0];
      ADDR_PART_NUM_HI: d = PART_NUMBER[15:8];
      ADDR_GRADE_VER: d = GRADE_VERSION;
      ADDR_SILICON_REV: d = SILICON_REV;
      ADDR_PROTO_REV: d = PROTO_REV;
      ADDR_MAKER_LO: d = MAKER_CODE[7:0];
      ADDR_MAKER_HI: d = MAKER_CODE[15:8];
      ADDR_SCRATCH: d = r.scratch;
      ADDR_LOOP_DEPTH: d = r.loop_depth;
      ADDR_XFER: d = {7'h00, r.xfer};
      ADDR_OPTIONS: d = {4'h0, r.options};
      ADDR_FRAME: d = {r.seed_policy, 1'b0, r.frame, r.divider};
      ADDR_LANES: d = r.lanes;
      ADDR_POWER_DOWN: d = r.power_down;
      default: d = 8'h00;
    endcase
    return d;
  endfunction : read_reg

  // lane usage from format and mean select: {out_en, chain_in}
  function automatic logic [7:0] lane_plan(input logic [1:0] fmt,
                                           input logic [1:0] avg);
    logic [7:0] p;
    p = 8'h00;
    case (fmt)
      2'b00: p = {4'b0001, 4'b0100};
      2'b01: p = {4'b0011, 4'b1100};
      2'b10: p = {4'b1111, 4'b0000};
      2'b11: begin
        case (avg)
          2'b00: p = {4'b0001, 4'b0100};
          2'b01: p = {4'b1101, 4'b0000};
          2'b10: p = {4'b0111, 4'b0000};
          2'b11: p = {4'b0011, 4'b1100};
          default: p = 8'h00;
        endcase
      end
      default: p = 8'h00;
    endcase
    return p;
  endfunction : lane_plan

  function automatic logic [5:0] frame_len(input logic [1:0] code);
    logic [5:0] n;
    case (code)
      2'b00: n = FRAME_BITS_16;
      2'b01: n = FRAME_BITS_16C;
      2'b10: n = FRAME_BITS_24;
      default: n = FRAME_BITS_24C;
    endcase
    return n;
  endfunction : frame_len

  assign sclk_rise = st.sclk_s[1] & ~st.sclk_s[2];
  assign sclk_fall = ~st.sclk_s[1] & st.sclk_s[2];
  assign cs_on = ~st.cs_s[1];
  assign cs_rise = st.cs_s[1] & ~st.cs_s[2];
  assign byte_done = cs_on & sclk_rise & (st.bitcnt == 3'd7);
  assign byte_in = {st.rx[6:0], st.sdi_s[1]};
  assign no_err = ~|(error_flags_i & error_enable_i);
  assign idle = ~busy_i & ~st.resetting;

  always_comb begin
    logic [6:0] base;
    logic [6:0] nxt;
    base = st.hdr_done ? st.addr : byte_in[6:0];
    // descending by default, wraps through loop depth when set
    nxt = st.regs.ascend ? base + 7'd1 : base - 7'd1;
    if (st.hdr_done && st.regs.loop_depth != 8'h00 &&
        st.loopcnt + 8'd1 >= st.regs.loop_depth) begin
      nxt = st.start;
    end
    step_addr = nxt;
  end

  assign rd_hdr = read_reg(byte_in[6:0], st.regs, st.resetting, idle,
                           no_err);
  assign rd_step = read_reg(step_addr, st.regs, st.resetting, idle,
                            no_err);
  assign rd_state = read_reg(ADDR_STATE_POWER, st.regs, st.resetting,
                             idle, no_err);

  always_comb begin
    next_st = st;
    next_st.sclk_s = {st.sclk_s[1:0], serial_clk_i};
    next_st.cs_s = {st.cs_s[1:0], serial_cs_n_i};
    next_st.sdi_s = {st.sdi_s[0], serial_data_i};
    next_st.lane_q = data_out_lane_zero_i;
    next_st.xfer_pulse = 1'b0;
    next_st.regs.xfer = 1'b0;
    if (cs_rise) begin
      next_st.hdr_done = 1'b0;
      next_st.bitcnt = 3'd0;
      next_st.refused = 1'b0;
    end else if (cs_on && sclk_rise) begin
      next_st.rx = byte_in;
      next_st.bitcnt = st.bitcnt + 3'd1;
      if (byte_done && !st.hdr_done) begin
        next_st.hdr_done = 1'b1;
        next_st.rd = byte_in[7];
        next_st.addr = byte_in[6:0];
        next_st.start = byte_in[6:0];
        next_st.loopcnt = 8'h00;
        next_st.tx = rd_hdr;
      end else if (byte_done && !st.refused) begin
        if (!st.rd) begin
          case (st.addr)
            ADDR_SETUP_A: begin
              next_st.regs.ascend = byte_in[A_ASCEND];
              next_st.regs.drive_on = byte_in[A_DRIVE];
              if (byte_in[A_RESET] || byte_in[A_RESET_SH]) begin
                next_st.resetting = 1'b1;
                next_st.rst_cnt = 5'd0;
              end
            end
            ADDR_SETUP_B: begin
              next_st.regs.one_shot = byte_in[B_ONE_SHOT];
              next_st.regs.rdsel = byte_in[B_RDSEL];
              next_st.regs.if_clear = byte_in[B_IF_CLEAR];
            end
            ADDR_STATE_POWER: next_st.regs.power_high =
              byte_in[S_POWER];
            ADDR_SCRATCH: next_st.regs.scratch = byte_in;
            ADDR_LOOP_DEPTH: next_st.regs.loop_depth = byte_in;
            ADDR_XFER: begin
              next_st.regs.xfer = byte_in[0];
              next_st.xfer_pulse = byte_in[0];
            end
            ADDR_OPTIONS: next_st.regs.options = byte_in[3:0];
            ADDR_FRAME: begin
              next_st.regs.seed_policy = byte_in[7];
              next_st.regs.frame = byte_in[5:4];
              next_st.regs.divider = byte_in[3:0];
            end
            ADDR_LANES: next_st.regs.lanes = byte_in;
            ADDR_POWER_DOWN: next_st.regs.power_down =
              byte_in & POWER_DOWN_MASK;
            default: next_st.regs.xfer = 1'b0;
          endcase
        end
        if (st.regs.one_shot) begin
          next_st.refused = 1'b1;
          next_st.tx = 8'h00;
        end else begin
          next_st.addr = step_addr;
          next_st.loopcnt = (step_addr == st.start) ? 8'h00 :
                            st.loopcnt + 8'd1;
          next_st.tx = rd_step;
        end
      end
    end
    if (cs_on && sclk_fall) begin
      next_st.sdo = st.tx[7];
      next_st.tx = {st.tx[6:0], 1'b0};
    end
    if (!cs_on) begin
      next_st.sdo = 1'b0;
    end
    if (st.resetting) begin
      next_st.rst_cnt = st.rst_cnt + 5'd1;
      if (st.rst_cnt == RST_LAST) begin
        next_st.resetting = 1'b0;
        next_st.regs = REGS_RESET;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '{sclk_s: 3'h0, cs_s: 3'h7, sdi_s: 2'h0, bitcnt: 3'h0,
              hdr_done: 1'b0, rd: 1'b0, refused: 1'b0, addr: 7'h00,
              start: 7'h00, loopcnt: 8'h00, rx: 8'h00, tx: 8'h00,
              sdo: 1'b0, lane_q: 1'b0, resetting: 1'b0,
              rst_cnt: 5'h00, xfer_pulse: 1'b0, regs: REGS_RESET};
    end else begin
      st <= next_st;
    end
  end

  // shared pin source and drive
  assign shared_serial_out_o = st.regs.options[2] ? st.lane_q :
                               st.sdo;
  assign shared_serial_out_oe_o = st.regs.drive_on;

  always_comb begin
    logic [7:0] plan;
    plan = lane_plan(st.regs.lanes[1:0], st.regs.lanes[3:2]);
    cfg_o.power_high = st.regs.power_high;
    cfg_o.antialias_select = st.regs.options[3];
    cfg_o.shared_out_source = st.regs.options[2];
    cfg_o.ref_gain_fix_on = st.regs.options[1];
    cfg_o.crystal_clock_out_on = st.regs.options[0];
    cfg_o.check_seed_policy = st.regs.seed_policy;
    cfg_o.frame_code = st.regs.frame;
    cfg_o.frame_bits = frame_len(st.regs.frame);
    cfg_o.data_clock_divider = st.regs.divider;
    cfg_o.chain_count = {1'b0, st.regs.lanes[7:4]} + 5'd1;
    cfg_o.mean_select = st.regs.lanes[3:2];
    cfg_o.lane_format = st.regs.lanes[1:0];
    cfg_o.lane_out_en = plan[7:4];
    cfg_o.lane_chain_in = plan[3:0];
    cfg_o.readback_first_stage = st.regs.rdsel;
    cfg_o.transfer_pulse = st.xfer_pulse;
    cfg_o.interface_logic_clear = st.regs.if_clear;
    cfg_o.power_down = st.regs.power_down;
    cfg_o.soft_reset_active = st.resetting;
  end

  // checks
  sequence s_reset_held;
    st.resetting [*8];
  endsequence

  property p_soft_reset_len;
    @(posedge clk_i) disable iff (!reset_n_i)
    $rose(st.resetting) |-> s_reset_held ##12 st.resetting ##1
      !st.resetting;
  endproperty
  a_soft_reset_len: assert property (p_soft_reset_len)
    else $error("soft reset length wrong");

  property p_soft_reset_defaults;
    @(posedge clk_i) disable iff (!reset_n_i)
    $fell(st.resetting) |-> st.regs.drive_on && !st.regs.ascend &&
      st.regs.one_shot && st.regs.scratch == 8'h00;
  endproperty
  a_soft_reset_defaults: assert property (p_soft_reset_defaults)
    else $error("registers not restored after soft reset");

  property p_addr_step;
    @(posedge clk_i) disable iff (!reset_n_i)
    (byte_done && st.hdr_done && !st.refused && !st.regs.one_shot &&
     st.regs.loop_depth == 8'h00 && !cs_rise) |=>
      st.addr == ($past(st.regs.ascend) ? $past(st.addr) + 7'd1 :
                  $past(st.addr) - 7'd1);
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("stream address stepped wrongly");

  property p_drive;
    @(posedge clk_i) disable iff (!reset_n_i)
    (byte_done && st.hdr_done && !st.refused && !st.rd &&
     st.addr == ADDR_SETUP_A && !st.resetting) |=>
      shared_serial_out_oe_o == $past(byte_in[A_DRIVE]);
  endproperty
  a_drive: assert property (p_drive)
    else $error("output enable does not follow drive bit");

  property p_one_shot_refuse;
    @(posedge clk_i) disable iff (!reset_n_i)
    (byte_done && st.hdr_done && st.regs.one_shot && !cs_rise) |=>
      st.refused ##1 (st.refused || !cs_on);
  endproperty
  a_one_shot_refuse: assert property (p_one_shot_refuse)
    else $error("streaming not refused in one-shot mode");

  property p_refused_addr_hold;
    @(posedge clk_i) disable iff (!reset_n_i)
    (st.refused && !cs_rise) |=> $stable(st.addr);
  endproperty
  a_refused_addr_hold: assert property (p_refused_addr_hold)
    else $error("address moved while refused");

  property p_idle_busy;
    @(posedge clk_i) disable iff (!reset_n_i)
    (busy_i || st.resetting) |-> !rd_state[S_IDLE];
  endproperty
  a_idle_busy: assert property (p_idle_busy)
    else $error("idle bit set while busy");

  property p_error_flag;
    @(posedge clk_i) disable iff (!reset_n_i)
    (|(error_flags_i & error_enable_i)) |-> !rd_state[S_NO_ERR];
  endproperty
  a_error_flag: assert property (p_error_flag)
    else $error("error-free flag set with enabled error");

  property p_lane_copy;
    @(posedge clk_i) disable iff (!reset_n_i)
    (st.regs.options[2] && $stable(st.regs.options[2])) |->
      shared_serial_out_o == $past(data_out_lane_zero_i);
  endproperty
  a_lane_copy: assert property (p_lane_copy)
    else $error("shared pin does not copy lane zero");

  property p_frame_bits;
    @(posedge clk_i) disable iff (!reset_n_i)
    cfg_o.frame_bits == (st.regs.frame[1] ? 6'd24 : 6'd16) +
      (st.regs.frame[0] ? 6'd6 : 6'd0);
  endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame length wrong");

  property p_xfer_pulse;
    @(posedge clk_i) disable iff (!reset_n_i)
    st.xfer_pulse |-> st.regs.xfer ##1 (!st.regs.xfer ||
      st.xfer_pulse);
  endproperty
  a_xfer_pulse: assert property (p_xfer_pulse)
    else $error("transfer bit did not self clear");

endmodule : aicr_regbank

// >>> testbench/aicr_host_model.sv
// Purpose: serial host model for the register port
// Assumes: clock idles low, data changes on fall, sampled on rise
// Notes: data line shows inverse of last bit outside frames
`timescale 1ns/1ps
module aicr_host_model (
  // clock
  input wire logic clk_i,
  // serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i,
  input wire logic miso_oe_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // half period of 6 clocks keeps the synchroniser margin
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    tick(6);
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        mosi_o <= tx[i][k];
        tick(6);
        sclk_o <= 1'b1;
        b = {b[6:0], miso_oe_i ? miso_i : 1'bz};
        tick(6);
        sclk_o <= 1'b0;
      end
      rx.push_back(b);
    end
    tick(6);
    cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o;
    tick(8);
  endtask : frame
endmodule : aicr_host_model

// >>> testbench/aicr_regbank_tb.sv
// Purpose: self-checking bench for the register bank
// Assumes: host model issues whole frames, one byte header
// Notes: identity parameters other than PROTO_REV set to arbitrary values here
`timescale 1ns/1ps
module aicr_regbank_tb;
  import aicr_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sclk, cs_n, mosi, sdo, sdo_oe;
  logic busy = 1'b0;
  logic lane0 = 1'b0;
  logic [7:0] flags = 8'h00;
  logic [7:0] ena = 8'h00;
  aicr_cfg_s cfg;
  logic [31:0] seed = 32'd68;
  logic [7:0] tx[$];
  logic [7:0] rx[$];
  int err_total = 0;
  int n_compared = 0;
  int xfer_n = 0;
  int sr_n = 0;

  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (cfg.transfer_pulse === 1'b1) xfer_n++;
    if (cfg.soft_reset_active === 1'b1) sr_n++;
  end

  aicr_regbank #(.PART_CLASS(8'h21), .PART_NUMBER(16'h3c4d),
    .GRADE_VERSION(8'h35), .SILICON_REV(8'h09),
    .MAKER_CODE(16'h6e2f)) i_aicr_regbank (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .serial_clk_i(sclk),
    .serial_cs_n_i(cs_n), .serial_data_i(mosi),
    .shared_serial_out_o(sdo), .shared_serial_out_oe_o(sdo_oe),
    .busy_i(busy), .error_flags_i(flags), .error_enable_i(ena),
    .data_out_lane_zero_i(lane0), .cfg_o(cfg));

  aicr_host_model i_aicr_host_model (.clk_i(clk_i), .sclk_o(sclk),
    .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(sdo), .miso_oe_i(sdo_oe));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] stat(input logic p);
    return STATE_FIXED_ONES | {2'b0, ~busy, ~|(flags & ena), 3'b0, p};
  endfunction : stat

  function automatic logic [7:0] rstv(input logic [6:0] a);
    case (a)
      ADDR_SETUP_A: return RST_SETUP_A;
      ADDR_SETUP_B: return RST_SETUP_B;
      ADDR_STATE_POWER: return stat(1'b0);
      ADDR_PART_CLASS: return 8'h21;
      ADDR_PART_NUM_LO: return 8'h4d;
      ADDR_PART_NUM_HI: return 8'h3c;
      ADDR_GRADE_VER: return 8'h35;
      ADDR_SILICON_REV: return 8'h09;
      ADDR_PROTO_REV: return 8'h01;
      ADDR_MAKER_LO: return 8'h2f;
      ADDR_MAKER_HI: return 8'h6e;
      default: return RST_BYTE;
    endcase
  endfunction : rstv

  function automatic logic [3:0] lane_en(input logic [1:0] m, f);
    logic [15:0] t;
    t = (f == 2'd3) ? 16'h37d1 : 16'h0f31;
    return t[4 * ((f == 2'd3) ? m : f) +: 4];
  endfunction : lane_en

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic xfer(input logic [7:0] h, input logic [23:0] d,
                      input int n);
    tx.delete();
    tx.push_back(h);
    for (int i = n - 1; i >= 0; i--) tx.push_back(d[i*8 +: 8]);
    i_aicr_host_model.frame(tx, rx);
  endtask : xfer

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer({1'b0, a}, {16'h0000, d}, 1);
  endtask : wr

  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    xfer({1'b1, a}, 24'h000000, 1);
    check(rx[1], e);
  endtask : rdchk

  task automatic cfgchk(input logic [7:0] o, f, l);
    check(cfg.antialias_select, o[3]);
    check({cfg.ref_gain_fix_on, cfg.crystal_clock_out_on}, o[1:0]);
    check(cfg.check_seed_policy, f[7]);
    check(cfg.frame_bits, 16 + 8 * f[5] + 6 * f[4]);
    check(cfg.frame_code, f[5:4]);
    check(cfg.data_clock_divider, f[3:0]);
    check(cfg.chain_count, l[7:4] + 1);
    check(cfg.lane_out_en, lane_en(l[3:2], l[1:0]));
  endtask : cfgchk

  initial begin
    logic [31:0] r;
    logic [7:0] o, f, l;
    logic [1:0] fm, mn;
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 21; i++) rdchk(7'(i), rstv(7'(i)));
    repeat (4) begin
      r = rnd();
      busy <= r[0];
      flags <= r[15:8];
      ena <= r[23:16];
      wr(ADDR_STATE_POWER, r[31:24]);
      rdchk(ADDR_STATE_POWER, stat(r[24]));
      check(cfg.power_high, r[24]);
    end
    busy <= 1'b0;
    flags <= 8'h01;
    ena <= 8'h01;
    rdchk(ADDR_STATE_POWER, 8'he0 | {7'h00, r[24]});
    flags <= 8'h00;
    repeat (3) begin
      r = rnd();
      wr(ADDR_SCRATCH, r[7:0]);
      rdchk(ADDR_SCRATCH, r[7:0]);
      wr(ADDR_PART_CLASS, r[15:8]);
      rdchk(ADDR_PART_CLASS, 8'h21);
      wr(ADDR_POWER_DOWN, r[23:16]);
      check(cfg.power_down, r[23:16] & POWER_DOWN_MASK);
      wr(7'h14, r[15:8]);
      rdchk(7'h14, 8'h00);
    end
    wr(ADDR_SETUP_A, 8'h20);
    @(posedge clk_i);
    check(sdo_oe, 1'b0);
    wr(ADDR_SETUP_A, 8'h30);
    rdchk(ADDR_SETUP_A, 8'h3c);
    wr(ADDR_SETUP_B, 8'h00);
    for (int dir = 0; dir < 2; dir++) begin
      r = rnd() & (dir ? 32'hfffffb : 32'hfbffff);
      wr(ADDR_SETUP_A, dir ? 8'h10 : 8'h30);
      xfer({1'b0, dir ? ADDR_LANES : ADDR_OPTIONS}, r[23:0], 3);
      o = dir ? r[7:0] : r[23:16];
      l = dir ? r[23:16] : r[7:0];
      f = r[15:8];
      rdchk(ADDR_OPTIONS, o & 8'h0f);
      rdchk(ADDR_FRAME, f & 8'hbf);
      rdchk(ADDR_LANES, l);
      cfgchk(o, f, l);
    end
    wr(ADDR_SETUP_A, 8'h30);
    wr(ADDR_LOOP_DEPTH, 8'h02);
    r = rnd();
    xfer({1'b0, ADDR_SCRATCH}, r[23:0], 3);
    rdchk(ADDR_SCRATCH, r[7:0]);
    wr(ADDR_LOOP_DEPTH, 8'h00);
    wr(ADDR_SETUP_B, 8'h80);
    xfer({1'b0, ADDR_OPTIONS}, {8'h09, ~f, 8'h00}, 3);
    rdchk(ADDR_FRAME, f & 8'hbf);
    rdchk(ADDR_OPTIONS, 8'h09);
    for (int k = 0; k < 7; k++) begin
      r = rnd();
      fm = (k < 3) ? 2'(k) : 2'd3;
      mn = (k < 3) ? r[1:0] : 2'(k - 3);
      wr(ADDR_LANES, {r[7:4], mn, fm});
      check(cfg.lane_out_en, lane_en(mn, fm));
      check({cfg.mean_select, cfg.lane_format}, {mn, fm});
      if (fm < 2 || (fm == 3 && (mn == 0 || mn == 3)))
        check(cfg.lane_chain_in,
          (fm == 0 || (fm == 3 && mn == 0)) ? 4'h4 : 4'hc);
    end
    wr(ADDR_SETUP_B, 8'ha2);
    check(cfg.readback_first_stage, 1'b1);
    check(cfg.interface_logic_clear, 1'b1);
    rdchk(ADDR_SETUP_B, 8'ha2);
    xfer_n = 0;
    wr(ADDR_XFER, 8'h01);
    check(xfer_n, 1);
    rdchk(ADDR_XFER, 8'h00);
    wr(ADDR_OPTIONS, 8'h04);
    repeat (6) begin
      r = rnd();
      lane0 <= r[0];
      repeat (3) @(posedge clk_i);
      check(sdo, r[0]);
    end
    wr(ADDR_OPTIONS, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_SCRATCH, 8'h77);
      sr_n = 0;
      wr(ADDR_SETUP_A, k ? 8'h11 : 8'h90);
      for (int w = 0; w < 200 && cfg.soft_reset_active !== 1'b0; w++)
        @(posedge clk_i);
      if (cfg.soft_reset_active !== 1'b0) begin
        err_total++;
        conclude();
      end
      check(sr_n, SOFT_RESET_CYCLES);
      rdchk(ADDR_SCRATCH, 8'h00);
      rdchk(ADDR_SETUP_A, RST_SETUP_A);
    end
    conclude();
  end
endmodule : aicr_regbank_tb
